// ### src/adcrr_consts.vh
// Purpose: constants for the converter result register block
// Assumes: APB, 32-bit data, word-aligned registers
// Notes:   all offsets are byte addresses
`ifndef ADCRR_CONSTS_VH
`define ADCRR_CONSTS_VH

`define ADCRR_ADDR_W        8
`define ADCRR_RES_W         12
`define ADCRR_NUM_REGS      12
`define ADCRR_CH_W          4

`define ADCRR_OFF_RES0      8'h00
`define ADCRR_OFF_PRIO      8'h30
`define ADCRR_OFF_CMP1      8'h34
`define ADCRR_OFF_CTRL      8'h38
`define ADCRR_OFF_ISTAT     8'h3c
`define ADCRR_OFF_IMASK     8'h40

`define ADCRR_BIT_STORED    12
`define ADCRR_BIT_OVR       13
`define ADCRR_BIT_POSW      14

`define ADCRR_CTRL_MON1EN   0

`define ADCRR_IRQ_NORMAL    0
`define ADCRR_IRQ_PRIO      1
`define ADCRR_IRQ_OVR       2
`define ADCRR_IRQ_W         3

`define ADCRR_CMP_RESET     12'h000
`endif

// ### src/adcrr_slot.v
// Purpose: one result slot with stored, overrun and port-switch flags
// Assumes: wr and rd are single-cycle pulses on pclk
// Notes:   set wins over a read clear in the same cycle, except overrun, which a read clears even when a write lands
`timescale 1ns/1ps
`include "adcrr_consts.vh"
module adcrr_slot #(
    parameter RES_W = `ADCRR_RES_W
) (
    // clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // load side
    input  wire             wr,
    input  wire [RES_W-1:0] wdata,
    input  wire             posw,
    // read side
    input  wire             rd,
    output reg  [RES_W-1:0] result_q,
    output reg              stored_q,
    output reg              ovr_q,
    output reg              posw_q
);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= {RES_W{1'b0}};
            stored_q <= 1'b0;
            ovr_q    <= 1'b0;
            posw_q   <= 1'b0;
        end else begin
            if (wr) begin
                result_q <= wdata;
            end
            if (wr) begin
                stored_q <= 1'b1;
            end else if (rd) begin
                stored_q <= 1'b0;
            end
            if (wr && stored_q && !rd) begin
                ovr_q <= 1'b1;
            end else if (rd) begin
                ovr_q <= 1'b0;
            end
            if (posw) begin
                posw_q <= 1'b1;
            end else if (rd) begin
                posw_q <= 1'b0;
            end
        end
    end
endmodule

// ### src/adcrr_sync.v
// Purpose: two-flop synchroniser for a bus of levels
// Assumes: inputs from outside the pclk domain
// Notes:   first stage read only by second stage
`timescale 1ns/1ps
module adcrr_sync #(
    parameter W = 1
) (
    // clock and reset
    input  wire         pclk,
    input  wire         presetn,
    // levels
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= {W{1'b0}};
            q      <= {W{1'b0}};
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// ### src/adcrr_top.v
// Purpose: result and monitor-1 compare registers of the converter, APB slave
// Assumes: sequencer on pclk delivers results as one-cycle strobes
// Notes:   read clears flags only on the APB access edge
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "adcrr_consts.vh"
module adcrr_top #(
    parameter RES_W  = `ADCRR_RES_W,
    parameter NREG   = `ADCRR_NUM_REGS,
    parameter PORT_W = 8
) (
    // clock and reset
    input  wire                   pclk,
    input  wire                   presetn,
    // apb slave
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [`ADCRR_ADDR_W-1:0] paddr,
    input  wire [31:0]            pwdata,
    input  wire [3:0]             pstrb,
    output wire                   pready,
    output reg  [31:0]            prdata,
    output wire                   pslverr,
    // sequencer side
    input  wire                   norm_valid,
    input  wire [`ADCRR_CH_W-1:0] norm_index,
    input  wire [RES_W-1:0]       norm_result,
    input  wire                   prio_valid,
    input  wire [RES_W-1:0]       prio_result,
    input  wire                   conv_busy,
    // shared port data register bits
    input  wire [PORT_W-1:0]      port_data,
    // monitor outputs
    output wire [RES_W-1:0]       monitor1_compare_value,
    output wire                   monitor1_enable,
    // interrupt
    output wire                   irq
);
    // ****************************************************************
    // apb decode
    // ****************************************************************
    wire access = psel & penable;
    wire wr_acc = access & pwrite;
    wire rd_acc = access & ~pwrite;

    function is_res;
        input [`ADCRR_ADDR_W-1:0] a;
        begin
            is_res = (a[1:0] == 2'b00) && (a < `ADCRR_OFF_PRIO);
        end
    endfunction

    function hit;
        input [`ADCRR_ADDR_W-1:0] a;
        input [`ADCRR_ADDR_W-1:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // result word: value, stored, overrun, port-switch, rest zero
    function [31:0] res_word;
        input [RES_W-1:0] v;
        input             st;
        input             ov;
        input             pw;
        begin
            res_word                    = 32'h0000_0000;
            res_word[RES_W-1:0]         = v;
            res_word[`ADCRR_BIT_STORED] = st;
            res_word[`ADCRR_BIT_OVR]    = ov;
            res_word[`ADCRR_BIT_POSW]   = pw;
        end
    endfunction

    wire sel_prio  = hit(paddr, `ADCRR_OFF_PRIO);
    wire sel_cmp1  = hit(paddr, `ADCRR_OFF_CMP1);
    wire sel_ctrl  = hit(paddr, `ADCRR_OFF_CTRL);
    wire sel_istat = hit(paddr, `ADCRR_OFF_ISTAT);
    wire sel_imask = hit(paddr, `ADCRR_OFF_IMASK);
    wire mapped    = is_res(paddr) | sel_prio | sel_cmp1 | sel_ctrl | sel_istat | sel_imask;
    wire [3:0] res_sel = paddr[5:2];

    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // ****************************************************************
    // control registers
    // ****************************************************************
    reg [RES_W-1:0]         cmp1_q;
    reg                     mon1en_q;
    reg [`ADCRR_IRQ_W-1:0]  istat_q;
    reg [`ADCRR_IRQ_W-1:0]  imask_q;

    assign monitor1_compare_value = cmp1_q;
    assign monitor1_enable        = mon1en_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp1_q   <= `ADCRR_CMP_RESET;
            mon1en_q <= 1'b0;
            imask_q  <= {`ADCRR_IRQ_W{1'b0}};
        end else if (wr_acc) begin
            // write accepted regardless of enable; software
            if (hit(paddr, `ADCRR_OFF_CMP1) && pstrb[0]) begin
                cmp1_q[7:0] <= pwdata[7:0];
            end
            if (hit(paddr, `ADCRR_OFF_CMP1) && pstrb[1]) begin
                cmp1_q[RES_W-1:8] <= pwdata[RES_W-1:8];
            end
            if (hit(paddr, `ADCRR_OFF_CTRL) && pstrb[0]) begin
                mon1en_q <= pwdata[`ADCRR_CTRL_MON1EN];
            end
            if (hit(paddr, `ADCRR_OFF_IMASK) && pstrb[0]) begin
                imask_q <= pwdata[`ADCRR_IRQ_W-1:0];
            end
        end
    end

    // ****************************************************************
    // port switch detect
    // ****************************************************************
    wire [PORT_W-1:0] port_s;
    reg  [PORT_W-1:0] port_prev_q;

    adcrr_sync #(
        .W (PORT_W)
    ) u_port_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (port_data),
        .q       (port_s)
    );

    reg       posw_pend_q;
    // sync and history read zero after reset: no compare until both
    // hold the pin level, else a nonzero idle level looks like a switch
    reg [2:0] port_fill_q;
    wire      port_chg = (port_s != port_prev_q) & conv_busy & port_fill_q[2];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_prev_q <= {PORT_W{1'b0}};
            port_fill_q <= 3'b000;
            posw_pend_q <= 1'b0;
        end else begin
            port_prev_q <= port_s;
            port_fill_q <= {port_fill_q[1:0], 1'b1};
            if (norm_valid) begin
                posw_pend_q <= 1'b0;
            end else if (port_chg) begin
                posw_pend_q <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // result landing on the read setup edge
    // ****************************************************************
    // prdata is taken at the setup edge; a result stored on that edge is
    // not in the word read, so its flags must survive the access edge
    wire setup_cyc = psel & ~penable;
    // out-of-range index stores nothing and raises no event
    wire norm_ok   = norm_valid & (norm_index < NREG);

    reg  norm_late_q;
    reg  prio_late_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            norm_late_q <= 1'b0;
            prio_late_q <= 1'b0;
        end else begin
            norm_late_q <= setup_cyc & norm_ok & (norm_index == res_sel);
            prio_late_q <= setup_cyc & prio_valid;
        end
    end

    // ****************************************************************
    // normal result slots
    // ****************************************************************
    wire [RES_W-1:0] res_val [0:NREG-1];
    wire [NREG-1:0]  res_st;
    wire [NREG-1:0]  res_ov;
    wire [NREG-1:0]  res_pw;
    wire [NREG-1:0]  slot_ovr_ev;

    genvar g;
    generate
        for (g = 0; g < NREG; g = g + 1) begin : g_slot
            wire wr_g = norm_valid && (norm_index == g);
            wire rd_g = rd_acc && is_res(paddr) && (res_sel == g) && !norm_late_q;
            assign slot_ovr_ev[g] = wr_g & res_st[g] & ~rd_g;
            adcrr_slot #(
                .RES_W (RES_W)
            ) u_slot (
                .pclk     (pclk),
                .presetn  (presetn),
                .wr       (wr_g),
                .wdata    (norm_result),
                .posw     (wr_g & (posw_pend_q | port_chg)),
                .rd       (rd_g),
                .result_q (res_val[g]),
                .stored_q (res_st[g]),
                .ovr_q    (res_ov[g]),
                .posw_q   (res_pw[g])
            );
        end
    endgenerate

    // ****************************************************************
    // priority result slot
    // ****************************************************************
    wire [RES_W-1:0] pr_val;
    wire             pr_st;
    wire             pr_ov;
    wire             pr_rd = rd_acc & hit(paddr, `ADCRR_OFF_PRIO) & ~prio_late_q;

    adcrr_slot #(
        .RES_W (RES_W)
    ) u_prio (
        .pclk     (pclk),
        .presetn  (presetn),
        .wr       (prio_valid),
        .wdata    (prio_result),
        .posw     (1'b0),
        .rd       (pr_rd),
        .result_q (pr_val),
        .stored_q (pr_st),
        .ovr_q    (pr_ov),
        .posw_q   ()
    );

    // ****************************************************************
    // interrupt status
    // ****************************************************************
    wire [`ADCRR_IRQ_W-1:0] ev;
    // overrun from any normal slot or from the priority slot
    wire norm_ovr_ev = |slot_ovr_ev;
    wire prio_ovr_ev = prio_valid & pr_st & ~pr_rd;
    assign ev[`ADCRR_IRQ_NORMAL] = norm_ok;
    assign ev[`ADCRR_IRQ_PRIO]   = prio_valid;
    assign ev[`ADCRR_IRQ_OVR]    = norm_ovr_ev | prio_ovr_ev;

    wire [`ADCRR_IRQ_W-1:0] w1c = (wr_acc && hit(paddr, `ADCRR_OFF_ISTAT) && pstrb[0])
                                ? pwdata[`ADCRR_IRQ_W-1:0] : {`ADCRR_IRQ_W{1'b0}};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_q <= {`ADCRR_IRQ_W{1'b0}};
        end else begin
            // set beats clear
            istat_q <= (istat_q & ~w1c) | ev;
        end
    end

    assign irq = |(istat_q & imask_q);

    // ****************************************************************
    // read mux
    // ****************************************************************
    reg [31:0] rd_d;
    always @* begin
        rd_d = 32'h0000_0000;
        if (is_res(paddr)) begin
            if (res_sel < NREG) begin
                rd_d = res_word(res_val[res_sel], res_st[res_sel],
                                res_ov[res_sel], res_pw[res_sel]);
            end
        end else if (hit(paddr, `ADCRR_OFF_PRIO)) begin
            rd_d = res_word(pr_val, pr_st, pr_ov, 1'b0);
        end else if (hit(paddr, `ADCRR_OFF_CTRL)) begin
            rd_d[`ADCRR_CTRL_MON1EN] = mon1en_q;
        end else if (hit(paddr, `ADCRR_OFF_ISTAT)) begin
            rd_d[`ADCRR_IRQ_W-1:0] = istat_q;
        end else if (hit(paddr, `ADCRR_OFF_IMASK)) begin
            rd_d[`ADCRR_IRQ_W-1:0] = imask_q;
        end
        // compare register reads as zero: write only
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_d;
        end
    end
endmodule

// ### test/adcrr_assertions.sv
// Purpose: port checks of the result register block
// Assumes: bound to adcrr_top, zero wait state apb
// Notes:   read-side flag checks, plus compare, enable, mask and error checks
`timescale 1ns/1ps
module adcrr_chk (
    // apb and sequencer
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        norm_valid,
    input wire logic        prio_valid,
    // outputs
    input wire logic [11:0] monitor1_compare_value,
    input wire logic        monitor1_enable,
    input wire logic        irq
);
    // ********
    // properties
    // ********
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_acc = psel && penable && !pwrite;
    wire wr_acc = psel && penable && pwrite;
    a_cmp_write_value: assert property (wr_acc && paddr == 8'h34 && pstrb == 4'hf
        |=> monitor1_compare_value == $past(pwdata[11:0])) else $error("compare not loaded");
    a_cmp_read_zero: assert property (rd_acc && paddr == 8'h34 |-> prdata == 32'h0)
        else $error("compare readback not zero");
    a_result_upper_zero: assert property (rd_acc && paddr < 8'h30 |-> prdata[31:15] == 17'h0)
        else $error("result upper bits set");
    a_prio_upper_zero: assert property (rd_acc && paddr == 8'h30 |-> prdata[31:14] == 18'h0)
        else $error("priority upper bits set");
    a_reread_flags_clear: assert property ((rd_acc && paddr < 8'h30 && !norm_valid)
        ##1 (!norm_valid && !penable && $stable(paddr))[*2] ##1 (rd_acc && $stable(paddr))
        |-> prdata[14:12] == 3'h0) else $error("flags survive a read");
    a_prio_reread_clear: assert property ((rd_acc && paddr == 8'h30 && !prio_valid)
        ##1 (!prio_valid && !penable && $stable(paddr))[*2] ##1 (rd_acc && $stable(paddr))
        |-> prdata[13:12] == 2'h0) else $error("priority flags survive a read");
    a_mask_zero_quiet: assert property (wr_acc && paddr == 8'h40 && pstrb[0] && pwdata[2:0] == 3'h0
        |=> !irq) else $error("irq with empty mask");
    a_enable_write: assert property (wr_acc && paddr == 8'h38 && pstrb[0]
        |=> monitor1_enable == $past(pwdata[0])) else $error("enable not loaded");
    a_slverr_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
endmodule
bind adcrr_top adcrr_chk adcrr_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pslverr(pslverr), .norm_valid(norm_valid), .prio_valid(prio_valid),
    .monitor1_compare_value(monitor1_compare_value), .monitor1_enable(monitor1_enable),
    .irq(irq));

// ### test/adcrr_seq_model.sv
// Purpose: conversion sequencer stand-in
// Assumes: conv called just after a rising edge
// Notes:   result lines carry inverted junk outside strobes
`timescale 1ns/1ps
module adcrr_seq_model (
    // clock
    input wire logic   pclk,
    // result strobes
    output logic       norm_valid,
    output logic [3:0] norm_index,
    output logic [11:0] norm_result,
    output logic       prio_valid,
    output logic [11:0] prio_result,
    output logic       conv_busy
);
    // ********
    // conversion
    // ********
    initial begin
        {norm_valid, prio_valid, conv_busy, norm_index, norm_result, prio_result} = '0;
    end
    task automatic conv(input bit pri, input logic [3:0] idx, input logic [11:0] v, input int d);
        @(posedge pclk);
        conv_busy <= 1'b1;
        repeat (d) @(posedge pclk);
        if (pri) begin
            prio_valid <= 1'b1;
            prio_result <= v;
        end else begin
            norm_valid <= 1'b1;
            norm_index <= idx;
            norm_result <= v;
        end
        @(posedge pclk);
        {norm_valid, prio_valid, conv_busy} <= 3'h0;
        norm_index <= ~idx;
        norm_result <= ~v;
        prio_result <= ~v;
    endtask
endmodule

// ### test/adc_result_registers_tb.sv
// Purpose: self-checking bench of the result register block
// Assumes: zero wait state slave, 40 MHz pclk
// Notes:   behavioural flag model compared at every result register read
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module adc_result_registers_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, e;
    logic [7:0] paddr = 0, port_data = 0;
    logic [31:0] pwdata = 0, prdata, r, x, seed = 32'hea106436;
    logic [3:0] pstrb = 4'hf, norm_index;
    logic [11:0] norm_result, prio_result, cmp_val;
    logic norm_valid, prio_valid, conv_busy, mon_en;
    int bad_count = 0, checks = 0, cyc = 0, i, k, d, res[13], st[13], ov[13], pw[13];
    always #12.5 pclk = ~pclk;
    adcrr_top adcrr_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .norm_valid(norm_valid), .norm_index(norm_index),
        .norm_result(norm_result), .prio_valid(prio_valid), .prio_result(prio_result),
        .conv_busy(conv_busy), .port_data(port_data), .monitor1_compare_value(cmp_val),
        .monitor1_enable(mon_en), .irq(irq));
    adcrr_seq_model adcrr_seq_model_i (.pclk(pclk), .norm_valid(norm_valid),
        .norm_index(norm_index), .norm_result(norm_result), .prio_valid(prio_valid),
        .prio_result(prio_result), .conv_busy(conv_busy));
    // ********
    // tasks
    // ********
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd_chk(input int n);
        apb(1'b0, (n < 12) ? 8'(n * 4) : 8'h30, 32'h0);
        `CHK("result word", 32'((pw[n] << 14) | (ov[n] << 13) | (st[n] << 12) | res[n]), r);
        `CHK("read error", 1'b0, e);
        {pw[n], ov[n], st[n]} = '0;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            conclude();
        end
    end
    // ********
    // scenarios
    // ********
    initial begin
        for (i = 0; i < 13; i++) {res[i], st[i], ov[i], pw[i]} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 13; i++) rd_chk(i);
        apb(1'b1, 8'h40, 32'h1);
        for (k = 0; k < 40; k++) begin
            x = rnd();
            i = x % 12;
            d = 1 + (x >> 4) % 7;
            if (d >= 5) port_data <= port_data ^ (x[15:8] | 8'h01);
            adcrr_seq_model_i.conv(1'b0, 4'(i), x[27:16], d);
            ov[i] |= st[i];
            st[i] = 1;
            res[i] = x[27:16];
            pw[i] |= (d >= 5);
            if (x[31]) rd_chk(i);
        end
        adcrr_seq_model_i.conv(1'b0, 4'hf, 12'hfff, 2);
        `CHK("irq set", 1'b1, irq);
        apb(1'b1, 8'h3c, 32'h7);
        repeat (2) @(posedge pclk);
        `CHK("irq clear", 1'b0, irq);
        for (i = 0; i < 12; i++) begin
            rd_chk(i);
            rd_chk(i);
        end
        for (k = 0; k < 2; k++) begin
            x = rnd();
            adcrr_seq_model_i.conv(1'b1, 4'h0, x[11:0], 2 + 4 * k);
            ov[12] |= st[12];
            st[12] = 1;
            res[12] = x[11:0];
        end
        rd_chk(12);
        rd_chk(12);
        apb(1'b1, 8'h40, 32'h0);
        repeat (2) @(posedge pclk);
        `CHK("irq masked", 1'b0, irq);
        apb(1'b1, 8'h40, 32'h2);
        repeat (2) @(posedge pclk);
        `CHK("irq priority", 1'b1, irq);
        apb(1'b0, 8'h3c, 32'h0);
        `CHK("status read", 32'h6, r);
        apb(1'b0, 8'h40, 32'h0);
        `CHK("mask read", 32'h2, r);
        apb(1'b1, 8'h38, 32'h1);
        @(posedge pclk);
        `CHK("monitor enable on", 1'b1, mon_en);
        apb(1'b0, 8'h38, 32'h0);
        `CHK("control read", 32'h1, r);
        apb(1'b1, 8'h38, 32'h0);
        x = rnd();
        apb(1'b1, 8'h34, x);
        @(posedge pclk);
        `CHK("compare value", x[11:0], cmp_val);
        `CHK("monitor enable", 1'b0, mon_en);
        apb(1'b0, 8'h34, 32'h0);
        `CHK("compare read", 32'h0, r);
        apb(1'b0, 8'h80, 32'h0);
        `CHK("unmapped error", 1'b1, e);
        `CHK("unmapped data", 32'h0, r);
        conclude();
    end
endmodule
